// ### design/ccd_channel_divider.sv
// channel clock divider: registers, sync handling and output routing
module ccd_channel_divider (
    // clock and reset
    input  wire logic       i_ref_clk,
    input  wire logic       i_rst,
    // register port
    input  wire logic [9:0] i_reg_addr,
    input  wire logic       i_reg_wr,
    input  wire logic       i_reg_rd,
    input  wire logic [7:0] i_reg_wdata,
    output logic      [7:0] o_reg_rdata,
    // chip-level controls
    input  wire logic       i_sync,
    input  wire logic [1:0] i_src_sel,
    // channel outputs
    output logic            o_channel_output_a,
    output logic            o_channel_output_b,
    output logic            o_channel_output_c,
    output logic      [1:0] o_chan_route,
    // divider status
    output logic            o_div_bypass,
    output logic            o_div_running,
    output logic            o_dcc_enable,
    // second divider fields
    output logic      [3:0] o_div1_low_cnt,
    output logic      [3:0] o_div1_high_cnt
);

    logic [7:0] duty0;
    logic [7:0] ctrl0;
    logic [7:0] route0;
    logic [7:0] duty1;
    logic [ccd_pkg::SYNC_STAGES-1:0] sync_ff;
    logic       sync_q;
    logic       ignore_sync;
    logic       static_high;
    logic       held;
    logic       run;
    logic       div_level;
    logic [2:0] chan_out;
    ccd_pkg::ccd_route_e next_route;

    function automatic logic hit(input logic [9:0] addr,
                                 input logic [9:0] offset);
        return addr == offset;
    endfunction

    // registers
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            duty0 <= ccd_pkg::DUTY0_RST;
        end else if (i_reg_wr && hit(i_reg_addr, ccd_pkg::REG_DUTY0)) begin
            duty0 <= i_reg_wdata;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            ctrl0 <= ccd_pkg::CTRL0_RST;
        end else if (i_reg_wr && hit(i_reg_addr, ccd_pkg::REG_CTRL0)) begin
            ctrl0 <= i_reg_wdata;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            route0 <= ccd_pkg::ROUTE0_RST;
        end else if (i_reg_wr && hit(i_reg_addr, ccd_pkg::REG_ROUTE0)) begin
            route0 <= i_reg_wdata;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            duty1 <= ccd_pkg::DUTY1_RST;
        end else if (i_reg_wr && hit(i_reg_addr, ccd_pkg::REG_DUTY1)) begin
            duty1 <= i_reg_wdata;
        end
    end

    // read data; unmapped offsets read zero
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            o_reg_rdata <= 8'h00;
        end else if (i_reg_rd) begin
            if (hit(i_reg_addr, ccd_pkg::REG_DUTY0)) begin
                o_reg_rdata <= duty0;
            end else if (hit(i_reg_addr, ccd_pkg::REG_CTRL0)) begin
                o_reg_rdata <= ctrl0;
            end else if (hit(i_reg_addr, ccd_pkg::REG_ROUTE0)) begin
                o_reg_rdata <= route0;
            end else if (hit(i_reg_addr, ccd_pkg::REG_DUTY1)) begin
                o_reg_rdata <= duty1;
            end else begin
                o_reg_rdata <= 8'h00;
            end
        end
    end

    // sync pin: accepted only once stages two and three agree
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            sync_ff <= '0;
        end else begin
            sync_ff <= {sync_ff[ccd_pkg::SYNC_STAGES-2:0], i_sync};
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            sync_q <= 1'b0;
        end else if (sync_ff[1] == sync_ff[2]) begin
            sync_q <= sync_ff[2];
        end
    end

    // divider control
    assign ignore_sync = ctrl0[ccd_pkg::IGN_SYNC_BIT];
    assign held        = sync_q && !ignore_sync;
    // forced high only counts with sync ignored, else the divider runs as usual
    assign static_high = ctrl0[ccd_pkg::FORCE_BIT] && ignore_sync;
    assign run = !ctrl0[ccd_pkg::BYPASS_BIT] && !held && !static_high;

    ccd_div_core u_div0 (
        .i_ref_clk   (i_ref_clk),
        .i_rst       (i_rst),
        .i_run       (run),
        .i_hold_level(static_high),
        .i_start_high(ctrl0[ccd_pkg::START_BIT]),
        .i_low_cnt   (duty0[ccd_pkg::LOW_MSB:ccd_pkg::LOW_LSB]),
        .i_high_cnt  (duty0[ccd_pkg::HIGH_MSB:ccd_pkg::HIGH_LSB]),
        .i_phase     (ctrl0[ccd_pkg::PHASE_MSB:ccd_pkg::PHASE_LSB]),
        .o_level     (div_level),
        .o_running   (o_div_running)
    );

    // route selection; an undefined source code changes nothing
    always_comb begin
        if (route0[ccd_pkg::PD_BIT]) begin
            next_route = ccd_pkg::ROUTE_OFF;
        end else if (!route0[ccd_pkg::DIRECT_BIT]) begin
            next_route = ccd_pkg::ROUTE_DIV;
        end else if (i_src_sel == ccd_pkg::SRC_VCO) begin
            next_route = ccd_pkg::ROUTE_VCO;
        end else if (i_src_sel == ccd_pkg::SRC_EXT) begin
            next_route = ccd_pkg::ROUTE_EXT;
        end else begin
            next_route = ccd_pkg::ROUTE_DIV;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            o_chan_route <= ccd_pkg::ROUTE_DIV;
        end else begin
            o_chan_route <= next_route;
        end
    end

    // the three outputs carry the divider level only on the divider route
    generate
        for (genvar g = 0; g < 3; g++) begin : g_out
            always_ff @(posedge i_ref_clk) begin
                if (i_rst) begin
                    chan_out[g] <= 1'b0;
                end else begin
                    chan_out[g] <= (next_route == ccd_pkg::ROUTE_DIV) &&
                                   div_level;
                end
            end
        end
    endgenerate

    assign o_channel_output_a = chan_out[0];
    assign o_channel_output_b = chan_out[1];
    assign o_channel_output_c = chan_out[2];

    // status flags
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            o_div_bypass <= 1'b0;
        end else begin
            o_div_bypass <= ctrl0[ccd_pkg::BYPASS_BIT];
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            o_dcc_enable <= 1'b1;
        end else begin
            o_dcc_enable <= !route0[ccd_pkg::DCC_OFF_BIT];
        end
    end

    assign o_div1_low_cnt  = duty1[ccd_pkg::LOW_MSB:ccd_pkg::LOW_LSB];
    assign o_div1_high_cnt = duty1[ccd_pkg::HIGH_MSB:ccd_pkg::HIGH_LSB];

    // helper logic for the checks below
    logic       level_d;
    logic [4:0] seg_len;
    logic [4:0] last_high;
    logic       seg_ok;
    logic       wr_d;
    logic [4:0] wait_cnt;

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            level_d   <= 1'b0;
            seg_len   <= 5'h00;
            last_high <= 5'h00;
            seg_ok    <= 1'b0;
            wr_d      <= 1'b0;
        end else begin
            level_d <= div_level;
            wr_d    <= i_reg_wr;
            if (div_level != level_d) begin
                seg_len <= 5'h01;
                // a write landing with the reload edge changes the count late
                seg_ok  <= o_div_running && !i_reg_wr && !wr_d;
                if (level_d) begin
                    last_high <= (seg_ok && !i_reg_wr) ? seg_len : 5'h00;
                end
            end else begin
                if (seg_len != 5'h1F) begin
                    seg_len <= seg_len + 5'h01;
                end
                if (!o_div_running || i_reg_wr) begin
                    seg_ok <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst || !run) begin
            wait_cnt <= 5'h00;
        end else if (!o_div_running) begin
            wait_cnt <= wait_cnt + 5'h01;
        end
    end

    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);

    sequence s_sync_release;
        $fell(held) && run && !static_high;
    endsequence

    a_low_time: assert property (
        $rose(div_level) && seg_ok && o_div_running |->
            seg_len == {1'b0, duty0[ccd_pkg::LOW_MSB:ccd_pkg::LOW_LSB]} + 5'h01)
        else $error("low time differs from low count");

    a_high_time: assert property (
        $fell(div_level) && seg_ok && o_div_running |->
            seg_len == {1'b0, duty0[ccd_pkg::HIGH_MSB:ccd_pkg::HIGH_LSB]} + 5'h01)
        else $error("high time differs from high count");

    a_period_sum: assert property (
        $rose(div_level) && seg_ok && o_div_running && last_high != 5'h00 |->
            last_high + seg_len ==
            {1'b0, duty0[ccd_pkg::LOW_MSB:ccd_pkg::LOW_LSB]} +
            {1'b0, duty0[ccd_pkg::HIGH_MSB:ccd_pkg::HIGH_LSB]} + 5'h02)
        else $error("period is not low plus high");

    a_bypass_stop: assert property (
        ctrl0[ccd_pkg::BYPASS_BIT] [*3] |-> o_div_bypass && !div_level &&
            !o_div_running)
        else $error("bypassed divider still active");

    a_sync_ignored: assert property (
        ignore_sync && o_div_running && run && !i_reg_wr |=> o_div_running)
        else $error("divider stopped while ignoring sync");

    a_sync_obeyed: assert property (
        sync_q && !ignore_sync |=> !o_div_running)
        else $error("divider ran during obeyed sync");

    a_force_high: assert property (
        static_high [*3] |-> div_level)
        else $error("forced high level missing");

    a_start_level: assert property (
        $rose(o_div_running) |->
            div_level == $past(ctrl0[ccd_pkg::START_BIT]))
        else $error("wrong start level");

    a_phase_delay: assert property (
        $rose(o_div_running) && $stable(ctrl0) |->
            wait_cnt ==
            {1'b0, ctrl0[ccd_pkg::PHASE_MSB:ccd_pkg::PHASE_LSB]} + 5'h01)
        else $error("start delay differs from phase offset");

    a_sync_restart: assert property (
        s_sync_release |-> ##[1:17] o_div_running)
        else $error("divider did not restart after sync");

    a_power_down: assert property (
        route0[ccd_pkg::PD_BIT] |=> o_chan_route == ccd_pkg::ROUTE_OFF &&
            chan_out == 3'b000)
        else $error("powered-down channel still drives");

    a_div_route: assert property (
        !route0[ccd_pkg::PD_BIT] && !route0[ccd_pkg::DIRECT_BIT] |=>
            o_chan_route == ccd_pkg::ROUTE_DIV &&
            o_channel_output_b == $past(div_level))
        else $error("outputs not fed by divider");

    a_direct_vco: assert property (
        !route0[ccd_pkg::PD_BIT] && route0[ccd_pkg::DIRECT_BIT] &&
            i_src_sel == ccd_pkg::SRC_VCO |=>
            o_chan_route == ccd_pkg::ROUTE_VCO && !o_channel_output_a)
        else $error("direct route to vco missing");

    a_direct_nochg: assert property (
        !route0[ccd_pkg::PD_BIT] && route0[ccd_pkg::DIRECT_BIT] &&
            i_src_sel == ccd_pkg::SRC_NOCHG |=>
            o_chan_route == ccd_pkg::ROUTE_DIV)
        else $error("no-effect source code changed route");

    a_dcc_off: assert property (
        route0[ccd_pkg::DCC_OFF_BIT] |=> !o_dcc_enable)
        else $error("duty-cycle correction not disabled");

    a_div1_default: assert property (
        $past(i_rst) |-> o_div1_low_cnt == 4'h3)
        else $error("second divider low default wrong");

endmodule

// ### design/ccd_pkg.sv
// constants and types shared by the channel clock divider files
package ccd_pkg;

    // register offsets
    localparam logic [9:0] REG_DUTY0  = 10'h190;
    localparam logic [9:0] REG_CTRL0  = 10'h191;
    localparam logic [9:0] REG_ROUTE0 = 10'h192;
    localparam logic [9:0] REG_DUTY1  = 10'h193;

    // reset values
    localparam logic [7:0] DUTY0_RST  = 8'h77;
    localparam logic [7:0] CTRL0_RST  = 8'h00;
    localparam logic [7:0] ROUTE0_RST = 8'h00;
    localparam logic [7:0] DUTY1_RST  = 8'h33;

    // duty count fields
    localparam int LOW_MSB  = 7;
    localparam int LOW_LSB  = 4;
    localparam int HIGH_MSB = 3;
    localparam int HIGH_LSB = 0;

    // divider control fields
    localparam int BYPASS_BIT   = 7;
    localparam int IGN_SYNC_BIT = 6;
    localparam int FORCE_BIT    = 5;
    localparam int START_BIT    = 4;
    localparam int PHASE_MSB    = 3;
    localparam int PHASE_LSB    = 0;

    // channel routing and power fields
    localparam int PD_BIT      = 2;
    localparam int DIRECT_BIT  = 1;
    localparam int DCC_OFF_BIT = 0;

    // global source select codes
    localparam logic [1:0] SRC_EXT   = 2'h0;
    localparam logic [1:0] SRC_NOCHG = 2'h1;
    localparam logic [1:0] SRC_VCO   = 2'h2;

    // pin synchroniser depth
    localparam int SYNC_STAGES = 3;

    typedef enum logic [1:0] {
        ROUTE_OFF = 2'b00,
        ROUTE_DIV = 2'b01,
        ROUTE_VCO = 2'b10,
        ROUTE_EXT = 2'b11
    } ccd_route_e;

    typedef enum logic [1:0] {
        DIV_HOLD  = 2'b00,
        DIV_DELAY = 2'b01,
        DIV_RUN   = 2'b10
    } ccd_div_state_e;

endpackage

// ### design/ccd_div_core.sv
// high/low counting core of one channel divider
module ccd_div_core (
    // clock and reset
    input  wire logic       i_ref_clk,
    input  wire logic       i_rst,
    // control
    input  wire logic       i_run,
    input  wire logic       i_hold_level,
    input  wire logic       i_start_high,
    input  wire logic [3:0] i_low_cnt,
    input  wire logic [3:0] i_high_cnt,
    input  wire logic [3:0] i_phase,
    // divided output and running flag
    output logic            o_level,
    output logic            o_running
);

    ccd_pkg::ccd_div_state_e state;
    logic [3:0]              cnt;

    // cycles minus one spent at the given level
    function automatic logic [3:0] half_len(input logic       lvl,
                                            input logic [3:0] lo,
                                            input logic [3:0] hi);
        return lvl ? hi : lo;
    endfunction

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            state <= ccd_pkg::DIV_HOLD;
        end else begin
            unique case (state)
                ccd_pkg::DIV_HOLD: begin
                    if (i_run && i_phase == 4'h0) begin
                        state <= ccd_pkg::DIV_RUN;
                    end else if (i_run) begin
                        state <= ccd_pkg::DIV_DELAY;
                    end
                end
                ccd_pkg::DIV_DELAY: begin
                    if (!i_run) begin
                        state <= ccd_pkg::DIV_HOLD;
                    end else if (cnt == 4'h0) begin
                        state <= ccd_pkg::DIV_RUN;
                    end
                end
                ccd_pkg::DIV_RUN: begin
                    if (!i_run) begin
                        state <= ccd_pkg::DIV_HOLD;
                    end
                end
                default: state <= ccd_pkg::DIV_HOLD;
            endcase
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            cnt <= 4'h0;
        end else begin
            unique case (state)
                ccd_pkg::DIV_HOLD: begin
                    if (i_phase == 4'h0) begin
                        cnt <= half_len(i_start_high, i_low_cnt, i_high_cnt);
                    end else begin
                        cnt <= i_phase - 4'h1;
                    end
                end
                ccd_pkg::DIV_DELAY: begin
                    if (cnt == 4'h0) begin
                        cnt <= half_len(i_start_high, i_low_cnt, i_high_cnt);
                    end else begin
                        cnt <= cnt - 4'h1;
                    end
                end
                ccd_pkg::DIV_RUN: begin
                    if (cnt == 4'h0) begin
                        cnt <= half_len(~o_level, i_low_cnt, i_high_cnt);
                    end else begin
                        cnt <= cnt - 4'h1;
                    end
                end
                default: cnt <= 4'h0;
            endcase
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            o_level <= 1'b0;
        end else begin
            unique case (state)
                ccd_pkg::DIV_HOLD: begin
                    if (i_run && i_phase == 4'h0) begin
                        o_level <= i_start_high;
                    end else begin
                        o_level <= i_hold_level;
                    end
                end
                ccd_pkg::DIV_DELAY: begin
                    if (cnt == 4'h0) begin
                        o_level <= i_start_high;
                    end
                end
                ccd_pkg::DIV_RUN: begin
                    if (cnt == 4'h0) begin
                        o_level <= ~o_level;
                    end
                end
                default: o_level <= 1'b0;
            endcase
        end
    end

    assign o_running = (state == ccd_pkg::DIV_RUN);

endmodule

// ### tb/ccd_channel_divider_tb.sv
// self-checking testbench for the channel clock divider
module ccd_channel_divider_tb;
    timeunit 1ns;
    timeprecision 100ps;

    logic       i_ref_clk;
    logic       i_rst;
    logic [9:0] i_reg_addr;
    logic       i_reg_wr;
    logic       i_reg_rd;
    logic [7:0] i_reg_wdata;
    logic [7:0] o_reg_rdata;
    logic       i_sync;
    logic [1:0] i_src_sel;
    logic       o_channel_output_a;
    logic       o_channel_output_b;
    logic       o_channel_output_c;
    logic [1:0] o_chan_route;
    logic       o_div_bypass;
    logic       o_div_running;
    logic       o_dcc_enable;
    logic [3:0] o_div1_low_cnt;
    logic [3:0] o_div1_high_cnt;
    int         err_count;
    int         check_count;

    ccd_channel_divider u_ccd_channel_divider (
        .i_ref_clk          (i_ref_clk),
        .i_rst              (i_rst),
        .i_reg_addr         (i_reg_addr),
        .i_reg_wr           (i_reg_wr),
        .i_reg_rd           (i_reg_rd),
        .i_reg_wdata        (i_reg_wdata),
        .o_reg_rdata        (o_reg_rdata),
        .i_sync             (i_sync),
        .i_src_sel          (i_src_sel),
        .o_channel_output_a (o_channel_output_a),
        .o_channel_output_b (o_channel_output_b),
        .o_channel_output_c (o_channel_output_c),
        .o_chan_route       (o_chan_route),
        .o_div_bypass       (o_div_bypass),
        .o_div_running      (o_div_running),
        .o_dcc_enable       (o_dcc_enable),
        .o_div1_low_cnt     (o_div1_low_cnt),
        .o_div1_high_cnt    (o_div1_high_cnt)
    );

    initial begin
        i_ref_clk = 1'b0;
        forever #5 i_ref_clk = ~i_ref_clk;
    end

    task automatic summarize();
        if (err_count == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [7:0] seen,
                         input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge i_ref_clk);
    endtask

    task automatic reg_wr(input logic [9:0] a, input logic [7:0] d);
        i_reg_addr  = a;
        i_reg_wdata = d;
        i_reg_wr    = 1'b1;
        cyc(1);
        i_reg_wr    = 1'b0;
    endtask

    task automatic reg_rd(input logic [9:0] a, output logic [7:0] d);
        i_reg_addr = a;
        i_reg_rd   = 1'b1;
        cyc(1);
        i_reg_rd   = 1'b0;
        d          = o_reg_rdata;
    endtask

    // cycles until output a is high; bounded so a stuck output ends it
    task automatic rise_delay(output int d);
        d = 0;
        while (o_channel_output_a !== 1'b1 && d < 300) begin
            cyc(1);
            d++;
        end
    endtask

    // one full high and low phase of output a, measured from a rising edge
    task automatic measure(output int hi, output int lo);
        int d;
        hi = 0;
        lo = 0;
        d  = 0;
        while (o_channel_output_a !== 1'b0 && d < 300) begin
            cyc(1);
            d++;
        end
        rise_delay(d);
        while (o_channel_output_a === 1'b1 && hi < 300) begin
            cyc(1);
            hi++;
        end
        while (o_channel_output_a === 1'b0 && lo < 300) begin
            cyc(1);
            lo++;
        end
    endtask

    task automatic t_reset_values();
        logic [7:0] d;
        reg_rd(ccd_pkg::REG_DUTY0, d);
        check("duty0", d, 8'h77);
        reg_rd(ccd_pkg::REG_CTRL0, d);
        check("ctrl0", d, 8'h00);
        reg_rd(ccd_pkg::REG_ROUTE0, d);
        check("route0", d, 8'h00);
        reg_rd(ccd_pkg::REG_DUTY1, d);
        check("duty1", d, 8'h33);
        check("div1 low", {4'h0, o_div1_low_cnt}, 8'h03);
        check("route", {6'h00, o_chan_route}, 8'h01);
        check("dcc", {7'h00, o_dcc_enable}, 8'h01);
        check("bypass", {7'h00, o_div_bypass}, 8'h00);
        reg_wr(10'h194, 8'hA5);
        reg_rd(10'h194, d);
        check("unmapped", d, 8'h00);
        reg_wr(ccd_pkg::REG_DUTY1, 8'hA5);
        cyc(1);
        check("div1 low", {4'h0, o_div1_low_cnt}, 8'h0A);
        check("div1 high", {4'h0, o_div1_high_cnt}, 8'h05);
    endtask

    task automatic t_period();
        logic [7:0] duty [3] = '{8'h77, 8'h21, 8'hF0};
        int hi;
        int lo;
        for (int k = 0; k < 3; k++) begin
            reg_wr(ccd_pkg::REG_DUTY0, duty[k]);
            measure(hi, lo);
            measure(hi, lo);
            check("high cycles", 8'(hi),
                  {4'h0, duty[k][3:0]} + 8'h01);
            check("low cycles", 8'(lo),
                  {4'h0, duty[k][7:4]} + 8'h01);
        end
        reg_wr(ccd_pkg::REG_DUTY0, 8'h77);
    endtask

    // restart latency compared across settings, so fixed sync delay cancels
    task automatic sync_restart(input logic [7:0] ctrl, output int d);
        reg_wr(ccd_pkg::REG_CTRL0, ctrl);
        i_sync = 1'b1;
        cyc(12);
        check("held running",
              {7'h00, o_div_running}, 8'h00);
        check("held output", {7'h00, o_channel_output_a}, 8'h00);
        i_sync = 1'b0;
        rise_delay(d);
    endtask

    task automatic t_sync();
        int d0;
        int d5;
        int dl;
        sync_restart(8'h10, d0);
        sync_restart(8'h15, d5);
        sync_restart(8'h00, dl);
        check("phase delay", 8'(d5 - d0), 8'h05);
        check("start level", 8'(dl - d0), 8'h08);
        reg_wr(ccd_pkg::REG_CTRL0, 8'h40);
        i_sync = 1'b1;
        cyc(12);
        check("ignore sync", {7'h00, o_div_running}, 8'h01);
        i_sync = 1'b0;
    endtask

    task automatic t_force();
        logic [2:0] lvl;
        int hi;
        int lo;
        reg_wr(ccd_pkg::REG_CTRL0, 8'h60);
        cyc(4);
        lvl = 3'b111;
        repeat (20) begin
            cyc(1);
            lvl &= {o_channel_output_a, o_channel_output_b,
                    o_channel_output_c};
        end
        check("forced high", {5'h00, lvl}, 8'h07);
        reg_wr(ccd_pkg::REG_CTRL0, 8'h20);
        measure(hi, lo);
        check("force no ignore", 8'(hi), 8'h08);
        reg_wr(ccd_pkg::REG_CTRL0, 8'h80);
        cyc(3);
        check("bypass", {7'h00, o_div_bypass}, 8'h01);
        check("bypass run", {7'h00, o_div_running}, 8'h00);
        reg_wr(ccd_pkg::REG_CTRL0, 8'h00);
    endtask

    task automatic t_route();
        ccd_pkg::ccd_route_e exp [4] = '{ccd_pkg::ROUTE_EXT,
            ccd_pkg::ROUTE_DIV, ccd_pkg::ROUTE_VCO, ccd_pkg::ROUTE_DIV};
        logic [2:0] seen;
        for (int s = 0; s < 4; s++) begin
            i_src_sel = 2'(s);
            reg_wr(ccd_pkg::REG_ROUTE0, 8'h02);
            cyc(3);
            check("direct route",
                  {6'h00, o_chan_route}, {6'h00, exp[s]});
            reg_wr(ccd_pkg::REG_ROUTE0, 8'h00);
            cyc(3);
            check("divider route", {6'h00, o_chan_route}, 8'h01);
        end
        reg_wr(ccd_pkg::REG_ROUTE0, 8'h05);
        cyc(3);
        seen = 3'b000;
        repeat (20) begin
            cyc(1);
            seen |= {o_channel_output_a, o_channel_output_b,
                     o_channel_output_c};
        end
        check("pd route", {6'h00, o_chan_route}, 8'h00);
        check("pd outputs", {5'h00, seen}, 8'h00);
        check("dcc off", {7'h00, o_dcc_enable}, 8'h00);
        reg_wr(ccd_pkg::REG_ROUTE0, 8'h00);
    endtask

    initial begin
        err_count   = 0;
        check_count = 0;
        i_rst       = 1'b1;
        i_reg_addr  = 10'h000;
        i_reg_wr    = 1'b0;
        i_reg_rd    = 1'b0;
        i_reg_wdata = 8'h00;
        i_sync      = 1'b0;
        i_src_sel   = 2'h1;
        cyc(6);
        i_rst = 1'b0;
        t_reset_values();
        t_period();
        t_sync();
        t_force();
        t_route();
        summarize();
    end

    // the whole run needs a few hundred cycles
    initial begin
        #200000;
        err_count++;
        summarize();
    end
endmodule
